// ### design/bscan_pkg.sv
// Shared constants and carrier types for the boundary-scan test registers.
// Assumes a separate TAP controller supplies one-hot state indications.
package bscan_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction register
   localparam int         IR_W        = 3;
   localparam logic [2:0] INS_EXTEST  = 3'h0;
   localparam logic [2:0] INS_IDCODE  = 3'h1;
   localparam logic [2:0] INS_SAMPLE  = 3'h2;
   localparam logic [2:0] INS_CLAMP   = 3'h3;
   localparam logic [2:0] INS_HIGHZ   = 3'h4;
   localparam logic [2:0] INS_BYPASS  = 3'h7;
   localparam logic [2:0] IR_CAPTURE  = 3'h1;

   ////////////////////////////////////////////////////////////////////////////
   // Identification register layout
   localparam int ID_W        = 32;
   localparam int ID_MARK_POS = 0;
   localparam int ID_MFR_LSB  = 1;
   localparam int ID_MFR_W    = 11;
   localparam int ID_PART_LSB = 12;
   localparam int ID_PART_W   = 16;
   localparam int ID_VER_LSB  = 28;
   localparam int ID_VER_W    = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Boundary register cell positions
   localparam int BSR_LEN              = 214;
   localparam int local_data_dir_cell  = 213;
   localparam int local_data_bit_low   = 212;
   localparam int local_data_bit_high  = 197;
   localparam int local_write_dir_cell = 185;
   localparam int local_write_strobe   = 184;
   localparam int local_read_dir_cell  = 183;
   localparam int local_read_strobe    = 182;
   localparam int local_addr_dir_cell  = 181;
   localparam int local_addr_bit_low   = 180;
   localparam int local_addr_bit_high  = 161;

   ////////////////////////////////////////////////////////////////////////////
   // Register port map
   localparam int         ADDR_W      = 4;
   localparam int         DATA_W      = 32;
   localparam logic [3:0] REG_STATUS  = 4'h0;
   localparam logic [3:0] REG_CTRL    = 4'h4;
   localparam logic [3:0] REG_IDCODE  = 4'h8;
   localparam int         CTRL_VER_LSB   = 0;
   localparam logic [3:0] CTRL_VER_RST   = 4'h0;
   localparam int         STAT_INS_LSB   = 0;
   localparam int         STAT_DRIVE_POS = 3;
   localparam int         STAT_HIGHZ_POS = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [3:0]        addr;
      logic [31:0]       wdata;
   } bus_req_s;

   typedef struct packed {
      logic tlr;
      logic capture_dr;
      logic shift_dr;
      logic update_dr;
      logic capture_ir;
      logic shift_ir;
      logic update_ir;
   } tap_state_s;

endpackage : bscan_pkg

// ### design/sync_2ff.sv
// Two-flop level synchroniser, any width.
// Assumes the input is a level that stays put long enough to be seen.
`timescale 1ns/10ps
module sync_2ff #(
   parameter int W = 1
) (
   // Clock and synchronous reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Level in and out
   input  wire logic [W-1:0] d,
   output      logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } state_s;

   state_s st_q;
   state_s st_d;

   always_comb begin
      st_d    = st_q;
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
      if (rst) begin
         st_d = '0;
      end
   end

   always_ff @(posedge clk) begin
      st_q <= st_d;
   end

   assign q = st_q.s2;

endmodule : sync_2ff

// ### design/shift_latch_reg.sv
// Test data register: shift stage plus separately latched parallel stage.
// Assumes capture, shift and update are mutually exclusive; W is two or more.
`timescale 1ns/10ps
module shift_latch_reg #(
   parameter int             W       = 8,
   parameter logic [W-1:0]   PAR_RST = '0
) (
   // Clock and synchronous reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Controls
   input  wire logic         capture,
   input  wire logic         shift,
   input  wire logic         update,
   // Data
   input  wire logic [W-1:0] cap_data,
   input  wire logic         sin,
   output      logic         sout,
   output      logic [W-1:0] par
);

   typedef struct packed {
      logic [W-1:0] sh;
      logic [W-1:0] par;
   } state_s;

   state_s st_q;
   state_s st_d;

   always_comb begin
      st_d = st_q;
      if (rst) begin
         st_d.sh  = PAR_RST;
         st_d.par = PAR_RST;
      end else begin
         if (capture) begin
            st_d.sh = cap_data;
         end else if (shift) begin
            // Input enters at the top, bit 0 leaves first
            st_d.sh = {sin, st_q.sh[W-1:1]};
         end
         if (update) begin
            st_d.par = st_q.sh;
         end
      end
   end

   always_ff @(posedge clk) begin
      st_q <= st_d;
   end

   assign sout = st_q.sh[0];
   assign par  = st_q.par;

endmodule : shift_latch_reg

// ### design/boundary_scan_test_registers.sv
// Instruction, bypass, identification and boundary registers of the test port,
// with pin muxing and a small register port on the system clock.
// Assumes a TAP controller on the test clock drives one-hot state flags and
// that the test-logic-reset flag acts as the test domain's synchronous reset.
`timescale 1ns/10ps

// Functional notes
// - External test drives output pins from latched cells
// - External test puts boundary register in path
// - Capture loads input pin levels into pin cells
// - Bypass uses one-bit stage, core undisturbed
// - Identification selected, code loaded at capture
// - Identification code shifts out on serial output
// - Test-logic-reset forces identification instruction
// - Code: bit0 one, maker, part, version
// - Clamp and high-impedance also select bypass
// - Identification: 32-bit shift plus latched stage
// - Every cell latched at data update, cleared at test-logic-reset
// - Cell 213 steers local data directions
// - Cell 181 steers local address directions
// - Cells 185, 183 steer write, read strobes
// - Three-bit instruction register with listed codes
module boundary_scan_test_registers #(
   // Arbitrary maker and part codes, not those of any real device
   parameter logic [10:0] MFR_CODE  = 11'h055,
   parameter logic [15:0] PART_CODE = 16'h0a5c
) (
   // System clock and reset
   input  wire logic                          clk,
   input  wire logic                          rstn,
   // Register port
   input  wire bscan_pkg::bus_req_s           bus_req,
   output      logic [bscan_pkg::DATA_W-1:0]  bus_rdata,
   // Test port
   input  wire logic                          test_clock_pin,
   input  wire bscan_pkg::tap_state_s         tap,
   input  wire logic                          test_serial_in,
   output      logic                          test_serial_out,
   // Pin cells, indexed by boundary position
   input  wire logic [bscan_pkg::BSR_LEN-1:0] cell_pin_in,
   input  wire logic [bscan_pkg::BSR_LEN-1:0] cell_core_out,
   input  wire logic [bscan_pkg::BSR_LEN-1:0] cell_core_oe,
   output      logic [bscan_pkg::BSR_LEN-1:0] cell_pin_out,
   output      logic [bscan_pkg::BSR_LEN-1:0] cell_pin_oe
);

   localparam int N = bscan_pkg::BSR_LEN;

   ////////////////////////////////////////////////////////////////////////////
   // Cell classification

   function automatic logic is_dir_cell(input int i);
      is_dir_cell = (i == bscan_pkg::local_data_dir_cell)  ||
                    (i == bscan_pkg::local_addr_dir_cell)  ||
                    (i == bscan_pkg::local_write_dir_cell) ||
                    (i == bscan_pkg::local_read_dir_cell);
   endfunction : is_dir_cell

   // Index of the direction cell governing pin cell i, or -1 if none
   function automatic int dir_cell_of(input int i);
      dir_cell_of = -1;
      if (i <= bscan_pkg::local_data_bit_low && i >= bscan_pkg::local_data_bit_high) begin
         dir_cell_of = bscan_pkg::local_data_dir_cell;
      end else if (i <= bscan_pkg::local_addr_bit_low &&
                   i >= bscan_pkg::local_addr_bit_high) begin
         dir_cell_of = bscan_pkg::local_addr_dir_cell;
      end else if (i == bscan_pkg::local_write_strobe) begin
         dir_cell_of = bscan_pkg::local_write_dir_cell;
      end else if (i == bscan_pkg::local_read_strobe) begin
         dir_cell_of = bscan_pkg::local_read_dir_cell;
      end
   endfunction : dir_cell_of

   ////////////////////////////////////////////////////////////////////////////
   // Test clock domain: instruction register

   logic [bscan_pkg::IR_W-1:0] ins;
   logic                       ir_sout;

   shift_latch_reg #(
      .W       (bscan_pkg::IR_W),
      .PAR_RST (bscan_pkg::INS_IDCODE)
   ) u_ir (
      .clk      (test_clock_pin),
      .rst      (tap.tlr),
      .capture  (tap.capture_ir),
      .shift    (tap.shift_ir),
      .update   (tap.update_ir),
      .cap_data (bscan_pkg::IR_CAPTURE),
      .sin      (test_serial_in),
      .sout     (ir_sout),
      .par      (ins)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Test clock domain: decode of the current instruction

   logic sel_bsr;
   logic sel_id;
   logic sel_byp;
   logic bsr_drive;
   logic pins_off;

   always_comb begin
      sel_bsr   = 1'b0;
      sel_id    = 1'b0;
      sel_byp   = 1'b0;
      bsr_drive = 1'b0;
      pins_off  = 1'b0;
      case (ins)
         bscan_pkg::INS_EXTEST: begin
            sel_bsr   = 1'b1;
            bsr_drive = 1'b1;
         end
         bscan_pkg::INS_SAMPLE: begin
            sel_bsr = 1'b1;
         end
         bscan_pkg::INS_IDCODE: begin
            sel_id = 1'b1;
         end
         bscan_pkg::INS_CLAMP: begin
            sel_byp   = 1'b1;
            bsr_drive = 1'b1;
         end
         bscan_pkg::INS_HIGHZ: begin
            sel_byp  = 1'b1;
            pins_off = 1'b1;
         end
         bscan_pkg::INS_BYPASS: begin
            sel_byp = 1'b1;
         end
         default: begin
            sel_byp = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Test clock domain: version field from the system side

   logic [bscan_pkg::ID_VER_W-1:0] ver_tck;
   logic [bscan_pkg::ID_VER_W-1:0] ver_q_out;

   sync_2ff #(
      .W (bscan_pkg::ID_VER_W)
   ) u_ver_sync (
      .clk (test_clock_pin),
      .rst (tap.tlr),
      .d   (ver_q_out),
      .q   (ver_tck)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Test clock domain: identification register

   logic [bscan_pkg::ID_W-1:0] id_value;
   logic                       id_sout;

   always_comb begin
      id_value = '0;
      id_value[bscan_pkg::ID_MARK_POS] = 1'b1;
      id_value[bscan_pkg::ID_MFR_LSB +: bscan_pkg::ID_MFR_W]   = MFR_CODE;
      id_value[bscan_pkg::ID_PART_LSB +: bscan_pkg::ID_PART_W] = PART_CODE;
      id_value[bscan_pkg::ID_VER_LSB +: bscan_pkg::ID_VER_W]   = ver_tck;
   end

   shift_latch_reg #(
      .W (bscan_pkg::ID_W)
   ) u_idr (
      .clk      (test_clock_pin),
      .rst      (tap.tlr),
      .capture  (tap.capture_dr && sel_id),
      .shift    (tap.shift_dr && sel_id),
      .update   (tap.update_dr && sel_id),
      .cap_data (id_value),
      .sin      (test_serial_in),
      .sout     (id_sout),
      .par      ()
   );

   ////////////////////////////////////////////////////////////////////////////
   // Test clock domain: boundary register

   logic [N-1:0] pin_sync;
   logic [N-1:0] bsr_cap;
   logic [N-1:0] bsr_par;
   logic         bsr_sout;

   // Pad levels arrive asynchronously to the test clock
   sync_2ff #(
      .W (N)
   ) u_pin_sync (
      .clk (test_clock_pin),
      .rst (tap.tlr),
      .d   (cell_pin_in),
      .q   (pin_sync)
   );

   // Direction cells capture their own latched value, pin cells the pad
   always_comb begin
      bsr_cap = '0;
      for (int i = 0; i < N; i++) begin
         bsr_cap[i] = is_dir_cell(i) ? bsr_par[i] : pin_sync[i];
      end
   end

   shift_latch_reg #(
      .W (N)
   ) u_bsr (
      .clk      (test_clock_pin),
      .rst      (tap.tlr),
      .capture  (tap.capture_dr && sel_bsr),
      .shift    (tap.shift_dr && sel_bsr),
      .update   (tap.update_dr && sel_bsr),
      .cap_data (bsr_cap),
      .sin      (test_serial_in),
      .sout     (bsr_sout),
      .par      (bsr_par)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Test clock domain: bypass stage and serial output

   typedef struct packed {
      logic byp;
   } link_s;

   link_s lk_q;
   link_s lk_d;

   always_comb begin
      lk_d = lk_q;
      if (tap.tlr) begin
         lk_d.byp = 1'b0;
      end else if (tap.capture_dr && sel_byp) begin
         lk_d.byp = 1'b0;
      end else if (tap.shift_dr && sel_byp) begin
         lk_d.byp = test_serial_in;
      end
   end

   always_ff @(posedge test_clock_pin) begin
      lk_q <= lk_d;
   end

   always_comb begin
      if (tap.shift_ir) begin
         test_serial_out = ir_sout;
      end else if (sel_bsr) begin
         test_serial_out = bsr_sout;
      end else if (sel_id) begin
         test_serial_out = id_sout;
      end else begin
         test_serial_out = lk_q.byp;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin muxing

   always_comb begin
      cell_pin_out = '0;
      cell_pin_oe  = '0;
      for (int i = 0; i < N; i++) begin
         int dc;
         dc = dir_cell_of(i);
         if (bsr_drive) begin
            cell_pin_out[i] = bsr_par[i];
            if (dc >= 0) begin
               cell_pin_oe[i] = bsr_par[dc];
            end else begin
               cell_pin_oe[i] = cell_core_oe[i];
            end
         end else begin
            cell_pin_out[i] = cell_core_out[i];
            cell_pin_oe[i]  = cell_core_oe[i] && !pins_off;
         end
         if (is_dir_cell(i)) begin
            cell_pin_out[i] = 1'b0;
            cell_pin_oe[i]  = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // System clock domain: mode flags brought over from the test side

   logic [bscan_pkg::IR_W+1:0] mode_clk;

   sync_2ff #(
      .W (bscan_pkg::IR_W + 2)
   ) u_mode_sync (
      .clk (clk),
      .rst (!rstn),
      .d   ({pins_off, bsr_drive, ins}),
      .q   (mode_clk)
   );

   ////////////////////////////////////////////////////////////////////////////
   // System clock domain: register port

   typedef struct packed {
      logic [bscan_pkg::DATA_W-1:0]   rdata;
      logic [bscan_pkg::ID_VER_W-1:0] ver;
   } host_s;

   host_s hs_q;
   host_s hs_d;

   logic [bscan_pkg::DATA_W-1:0] status_word;
   logic [bscan_pkg::DATA_W-1:0] ctrl_word;
   logic [bscan_pkg::DATA_W-1:0] id_word;

   always_comb begin
      status_word = '0;
      status_word[bscan_pkg::STAT_INS_LSB +: bscan_pkg::IR_W] = mode_clk[bscan_pkg::IR_W-1:0];
      status_word[bscan_pkg::STAT_DRIVE_POS] = mode_clk[bscan_pkg::IR_W];
      status_word[bscan_pkg::STAT_HIGHZ_POS] = mode_clk[bscan_pkg::IR_W+1];
      ctrl_word = '0;
      ctrl_word[bscan_pkg::CTRL_VER_LSB +: bscan_pkg::ID_VER_W] = hs_q.ver;
      id_word = '0;
      id_word[bscan_pkg::ID_MARK_POS] = 1'b1;
      id_word[bscan_pkg::ID_MFR_LSB +: bscan_pkg::ID_MFR_W]   = MFR_CODE;
      id_word[bscan_pkg::ID_PART_LSB +: bscan_pkg::ID_PART_W] = PART_CODE;
      id_word[bscan_pkg::ID_VER_LSB +: bscan_pkg::ID_VER_W]   = hs_q.ver;
   end

   always_comb begin
      hs_d       = hs_q;
      hs_d.rdata = '0;
      if (bus_req.rd) begin
         case (bus_req.addr)
            bscan_pkg::REG_STATUS: begin
               hs_d.rdata = status_word;
            end
            bscan_pkg::REG_CTRL: begin
               hs_d.rdata = ctrl_word;
            end
            bscan_pkg::REG_IDCODE: begin
               hs_d.rdata = id_word;
            end
            default: begin
               hs_d.rdata = '0;
            end
         endcase
      end
      if (bus_req.wr && bus_req.addr == bscan_pkg::REG_CTRL) begin
         hs_d.ver = bus_req.wdata[bscan_pkg::CTRL_VER_LSB +: bscan_pkg::ID_VER_W];
      end
      if (!rstn) begin
         hs_d.rdata = '0;
         hs_d.ver   = bscan_pkg::CTRL_VER_RST;
      end
   end

   always_ff @(posedge clk) begin
      hs_q <= hs_d;
   end

   assign bus_rdata = hs_q.rdata;
   assign ver_q_out = hs_q.ver;

endmodule : boundary_scan_test_registers

// ### verification/bscan_checker_assertions.sv
// Concurrent checks on the boundary-scan test registers' ports.
// Assumes one-hot tap flags; shadows the instruction and boundary path.
`timescale 1ns/10ps
module bscan_checker #(
   parameter logic [10:0] MFR_CODE  = 11'h055,
   parameter logic [15:0] PART_CODE = 16'h0a5c
) (
   // System side
   input wire logic                          clk,
   input wire logic                          rstn,
   input wire bscan_pkg::bus_req_s           bus_req,
   input wire logic [bscan_pkg::DATA_W-1:0]  bus_rdata,
   // Test side
   input wire logic                          test_clock_pin,
   input wire bscan_pkg::tap_state_s         tap,
   input wire logic                          test_serial_in,
   input wire logic                          test_serial_out,
   input wire logic [bscan_pkg::BSR_LEN-1:0] cell_pin_in,
   input wire logic [bscan_pkg::BSR_LEN-1:0] cell_core_out,
   input wire logic [bscan_pkg::BSR_LEN-1:0] cell_core_oe,
   input wire logic [bscan_pkg::BSR_LEN-1:0] cell_pin_out,
   input wire logic [bscan_pkg::BSR_LEN-1:0] cell_pin_oe
);
   localparam logic [213:0] DIRM = (214'h1 << 213) | (214'h1 << 185) | (214'h1 << 183)
                                 | (214'h1 << 181);
   logic [2:0]   irs_q, ir_q;
   logic [213:0] sh_q, lat_q;
   logic         bnd, byp, ext;
   assign ext = ir_q == bscan_pkg::INS_EXTEST;
   assign bnd = ext || ir_q == bscan_pkg::INS_SAMPLE;
   assign byp = ir_q[2] || ir_q == bscan_pkg::INS_CLAMP;

   ////////////////////////////////////////////////////////////////////////////
   // Shadow of instruction and boundary registers
   always_ff @(posedge test_clock_pin) begin
      if (tap.tlr) begin
         irs_q <= '0;
         ir_q  <= bscan_pkg::INS_IDCODE;
         sh_q  <= '0;
         lat_q <= '0;
      end else begin
         if (tap.capture_ir) irs_q <= bscan_pkg::IR_CAPTURE;
         if (tap.shift_ir) irs_q <= {test_serial_in, irs_q[2:1]};
         if (tap.update_ir) ir_q <= irs_q;
         if (bnd && tap.capture_dr) sh_q <= (cell_pin_in & ~DIRM) | (lat_q & DIRM);
         if (bnd && tap.shift_dr) sh_q <= {test_serial_in, sh_q[213:1]};
         if (bnd && tap.update_dr) lat_q <= sh_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Test clock domain
   sequence id_cap_s;
      (ir_q == bscan_pkg::INS_IDCODE) && tap.capture_dr;
   endsequence
   a_id_lsb: assert property (@(posedge test_clock_pin) disable iff (tap.tlr)
      id_cap_s |=> test_serial_out) else $error("id bit 0 not one");
   a_id_shift: assert property (@(posedge test_clock_pin) disable iff (tap.tlr)
      id_cap_s ##1 tap.shift_dr [*8] |=> test_serial_out == MFR_CODE[7])
      else $error("id code shifted wrongly");
   a_byp_cap: assert property (@(posedge test_clock_pin) disable iff (tap.tlr)
      byp && tap.capture_dr |=> !test_serial_out) else $error("bypass capture not 0");
   a_byp_shift: assert property (@(posedge test_clock_pin) disable iff (tap.tlr)
      byp && tap.shift_dr |=> test_serial_out == $past(test_serial_in))
      else $error("bypass stage not one bit");
   a_byp_pins: assert property (@(posedge test_clock_pin) disable iff (tap.tlr)
      ir_q == bscan_pkg::INS_BYPASS |-> cell_pin_out == cell_core_out
      && cell_pin_oe == cell_core_oe) else $error("bypass disturbs pins");
   a_bsr_scan: assert property (@(posedge test_clock_pin) disable iff (tap.tlr)
      bnd && (tap.capture_dr || tap.shift_dr) |=> test_serial_out == sh_q[0])
      else $error("boundary path wrong");
   a_ext_out: assert property (@(posedge test_clock_pin) disable iff (tap.tlr)
      ext |-> cell_pin_out[212:197] == lat_q[212:197] && cell_pin_out[180:161] == lat_q[180:161])
      else $error("pins not from latched cells");
   a_ext_dir: assert property (@(posedge test_clock_pin) disable iff (tap.tlr)
      ext |-> cell_pin_oe[212:197] == {16{lat_q[213]}} && cell_pin_oe[180:161] == {20{lat_q[181]}}
      && cell_pin_oe[184] == lat_q[185] && cell_pin_oe[182] == lat_q[183])
      else $error("direction cells wrong");

   ////////////////////////////////////////////////////////////////////////////
   // System clock domain
   a_rd_ident: assert property (@(posedge clk) disable iff (!rstn)
      $past(bus_req.rd) && $past(bus_req.addr) == bscan_pkg::REG_IDCODE
      |-> bus_rdata[27:0] == {PART_CODE, MFR_CODE, 1'b1}) else $error("id word wrong");
   a_rd_idle: assert property (@(posedge clk) disable iff (!rstn)
      !$past(bus_req.rd) |-> bus_rdata == 32'h0) else $error("read data not idle");
endmodule : bscan_checker

bind boundary_scan_test_registers bscan_checker #(.MFR_CODE(MFR_CODE), .PART_CODE(PART_CODE))
   u_bscan_checker (.clk, .rstn, .bus_req, .bus_rdata, .test_clock_pin, .tap, .test_serial_in,
   .test_serial_out, .cell_pin_in, .cell_core_out, .cell_core_oe, .cell_pin_out, .cell_pin_oe);

// ### verification/tap_tester.sv
// Model of the external boundary-scan tester.
// Assumes it owns the test clock, which only runs inside its scans.
`timescale 1ns/10ps
module tap_tester (
   // Link
   output logic                  test_clock_pin,
   output bscan_pkg::tap_state_s tap,
   output logic                  test_serial_in,
   input  wire logic             test_serial_out
);
   initial begin
      test_clock_pin = 1'b0;
      tap = '0;
      test_serial_in = 1'b0;
   end

   // One test clock period; serial in toggles when it carries no data
   task automatic tick(input bscan_pkg::tap_state_s st, input logic di, output logic d);
      tap <= st;
      test_serial_in <= (st.shift_dr || st.shift_ir) ? di : ~test_serial_in;
      #62.5;
      d = test_serial_out;
      test_clock_pin = 1'b1;
      #62.5;
      test_clock_pin = 1'b0;
   endtask : tick

   task automatic reset_tap();
      logic d;
      repeat (3) tick(7'h40, 1'b0, d);
   endtask : reset_tap

   task automatic load_ir(input logic [2:0] code);
      logic d;
      // Pass through the select states, as a real controller must
      repeat (2) tick(7'h00, 1'b0, d);
      tick(7'h04, 1'b0, d);
      for (int i = 0; i < 3; i++)
         tick(7'h02, code[i], d);
      tick(7'h01, 1'b0, d);
   endtask : load_ir

   task automatic scan_dr(input int n, input logic [255:0] din, output logic [255:0] dout);
      logic d;
      dout = '0;
      // Idle and select states give the synchronisers their two edges
      repeat (2) tick(7'h00, 1'b0, d);
      tick(7'h20, 1'b0, d);
      for (int i = 0; i < n; i++) begin
         tick(7'h10, din[i], d);
         dout[i] = d;
      end
      tick(7'h08, 1'b0, d);
   endtask : scan_dr
endmodule : tap_tester

// ### verification/tb_top.sv
// Self-checking bench for the boundary-scan test registers.
// Assumes the tester model sequences the tap flags and owns the test clock.
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
   localparam logic [10:0] MFR  = 11'h055;  // Arbitrary value
   localparam logic [15:0] PART = 16'h0a5c; // Arbitrary value
   // Direction cells are not pads; the core never drives them
   localparam logic [213:0] DIRM = (214'h1 << 213) | (214'h1 << 185) | (214'h1 << 183)
                                 | (214'h1 << 181);
   logic                  clk, rstn, test_clock_pin, test_serial_in, test_serial_out;
   bscan_pkg::bus_req_s   bus_req;
   logic [31:0]           bus_rdata, ver, idw;
   bscan_pkg::tap_state_s tap;
   logic [213:0]          cell_pin_in, cell_core_out, cell_core_oe, cell_pin_out, cell_pin_oe;
   logic [255:0]          din, dout;
   logic                  q[$];
   logic [2:0]            bcode[5] = '{3'h7, 3'h3, 3'h4, 3'h5, 3'h6};
   int                    n_errors, total_checks;

   boundary_scan_test_registers #(.MFR_CODE(MFR), .PART_CODE(PART)) u_boundary_scan_test_registers (
      .clk, .rstn, .bus_req, .bus_rdata, .test_clock_pin, .tap, .test_serial_in, .test_serial_out,
      .cell_pin_in, .cell_core_out, .cell_core_oe, .cell_pin_out, .cell_pin_oe);
   tap_tester u_tap_tester (.test_clock_pin, .tap, .test_serial_in, .test_serial_out);

   initial clk = 1'b0;
   always #5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus_req <= '0;
   endtask : bus_wr

   task automatic bus_rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk);
      bus_req <= '0;
      #1;
      `CHK(bus_rdata, e)
   endtask : bus_rd

   function automatic logic [213:0] rnd();
      logic [223:0] v;
      for (int k = 0; k < 7; k++)
         v[k*32 +: 32] = $urandom;
      return v[213:0];
   endfunction : rnd

   // Captured bit: direction cells keep their latched value
   function automatic logic cap(int i, logic [255:0] l);
      return (i inside {213, 185, 183, 181}) ? l[i] : cell_pin_in[i];
   endfunction : cap

   task automatic check_q();
      for (int i = 0; q.size() > 0; i++)
         `CHK(dout[i], q.pop_front())
   endtask : check_q

   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   initial begin
      #500000;
      n_errors++;
      complete_run();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   initial begin
      rstn = 1'b0;
      bus_req = '0;
      cell_pin_in = '0;
      n_errors = 0;
      total_checks = 0;
      ver = $urandom(48750);
      cell_core_out = rnd() & ~DIRM;
      cell_core_oe = rnd() & ~DIRM;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      u_tap_tester.reset_tap();
      idw = {4'h0, PART, MFR, 1'b1};
      for (int i = 0; i < 32; i++)
         q.push_back(idw[i]);
      u_tap_tester.scan_dr(32, '0, dout);
      check_q();
      `CHK(cell_pin_out, cell_core_out)
      // Version field through the register port, then on the serial path
      ver = $urandom;
      ver[31:4] = '0;
      idw[31:28] = ver[3:0];
      bus_wr(bscan_pkg::REG_CTRL, ver);
      bus_rd(bscan_pkg::REG_CTRL, ver);
      bus_wr(bscan_pkg::REG_IDCODE, ~idw);
      bus_rd(bscan_pkg::REG_IDCODE, idw);
      bus_rd(4'hc, 32'h0);
      bus_rd(bscan_pkg::REG_STATUS, 32'h1);
      u_tap_tester.reset_tap();
      for (int i = 0; i < 32; i++)
         q.push_back(idw[i]);
      u_tap_tester.scan_dr(32, '0, dout);
      check_q();
      // Each bypass-path code (bypass, clamp, high-impedance, unused 5 and 6) with the one-bit path
      foreach (bcode[k]) begin
         u_tap_tester.load_ir(bcode[k]);
         din = {224'h0, $urandom};
         q.push_back(1'b0);
         for (int i = 0; i < 7; i++)
            q.push_back(din[i]);
         u_tap_tester.scan_dr(8, din, dout);
         check_q();
         if (bcode[k] == bscan_pkg::INS_BYPASS) `CHK(cell_pin_oe, cell_core_oe)
         repeat (5) @(posedge clk);
         bus_rd(bscan_pkg::REG_STATUS, {27'h0, bcode[k] == 3'h4, bcode[k] == 3'h3, bcode[k]});
      end
      // External test: capture pads, drive pins from cells
      u_tap_tester.reset_tap();
      cell_pin_in <= rnd();
      u_tap_tester.load_ir(bscan_pkg::INS_EXTEST);
      din = {42'h0, rnd()};
      for (int i = 0; i < 214; i++)
         q.push_back(cap(i, '0));
      u_tap_tester.scan_dr(214, din, dout);
      check_q();
      `CHK(cell_pin_out[212:197], din[212:197])
      `CHK(cell_pin_out[180:161], din[180:161])
      `CHK(cell_pin_oe[212:197], {16{din[213]}})
      `CHK(cell_pin_oe[180:161], {20{din[181]}})
      `CHK({cell_pin_oe[184], cell_pin_oe[182]}, {din[185], din[183]})
      for (int i = 0; i < 214; i++)
         q.push_back(cap(i, din));
      u_tap_tester.scan_dr(214, ~din, dout);
      check_q();
      complete_run();
   end
endmodule : tb_top
